//--- hdl/pcmfs_pair.sv
// Purpose: bit-clock side serial engine of one PCM port pair (one input, one output)
// Assumes: strobe and data pins are synchronous to bit_clk
// Notes: output bits lag the sampled window by one bit clock
`timescale 1ns/10ps
module pcmfs_pair
  import pcmfs_pkg::*;
(
  input wire logic bit_clk,
  input wire logic rst_n,
  input wire logic ssi,
  input wire logic [8:0] pos,
  input wire logic strobe_in,
  input wire logic mode_bit,
  input wire logic wide,
  input wire logic din,
  input wire logic [15:0] tx_word,
  output logic dout_q,
  output logic dout_oe_n_q,
  output logic [15:0] rx_word_q,
  output logic rx_bad_q,
  output logic rx_tgl_q
);
  logic strobe_q, din_q, win_q, win;
  logic [4:0] width, cnt_q;
  logic [8:0] start;
  logic [15:0] rx_sreg_q, tx_sreg_q;

  assign width = wide ? W_WIDE : W_NARROW;
  // In framed modes the strobe pin is a mode bit picking the slot
  assign start = {4'h0, mode_bit, strobe_q, 3'h0};
  assign win = ssi ? strobe_q : (pos >= start) && (pos < start + 9'(width));

  always_ff @(posedge bit_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_q <= 1'b0;
      din_q <= 1'b0;
      win_q <= 1'b0;
    end
    else
    begin
      strobe_q <= strobe_in;
      din_q <= din;
      win_q <= win;
    end
  end

  // Receive shifter, MSB first; the word closes when the window ends
  always_ff @(posedge bit_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sreg_q <= 16'h0000;
      cnt_q <= 5'h00;
      rx_word_q <= 16'h0000;
      rx_bad_q <= 1'b0;
      rx_tgl_q <= 1'b0;
    end
    else
    begin
      if (win)
      begin
        rx_sreg_q <= {rx_sreg_q[14:0], din_q};
        cnt_q <= cnt_q + 5'h01;
      end
      else if (!win_q)
        cnt_q <= 5'h00;
      if (win_q && !win)
      begin
        rx_word_q <= wide ? rx_sreg_q : {8'h00, rx_sreg_q[7:0]};
        rx_bad_q <= cnt_q != width;
        rx_tgl_q <= !rx_tgl_q;
      end
    end
  end

  // Transmit shifter reloads only outside the window, so a late update cannot tear a word
  always_ff @(posedge bit_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sreg_q <= 16'h0000;
      dout_q <= 1'b0;
      dout_oe_n_q <= 1'b1;
    end
    else if (win)
    begin
      tx_sreg_q <= {tx_sreg_q[14:0], 1'b0};
      dout_q <= tx_sreg_q[15];
      dout_oe_n_q <= 1'b0;
    end
    else
    begin
      tx_sreg_q <= wide ? tx_word : {tx_word[7:0], 8'h00};
      dout_q <= 1'b0;
      dout_oe_n_q <= 1'b1;
    end
  end

  property p_strobe_drive;
    @(posedge bit_clk) disable iff (!rst_n) ssi && strobe_q |=> !dout_oe_n_q;
  endproperty
  a_strobe_drive: assert property (p_strobe_drive) else $error("strobe window not driven");
  property p_wide_word;
    @(posedge bit_clk) disable iff (!rst_n)
      win_q && !win && wide && cnt_q == W_WIDE |=> $changed(rx_tgl_q) && !rx_bad_q;
  endproperty
  a_wide_word: assert property (p_wide_word) else $error("16-bit window not closed");
  property p_slot_start;
    @(posedge bit_clk) disable iff (!rst_n) !ssi && pos == start |-> win;
  endproperty
  a_slot_start: assert property (p_slot_start) else $error("slot not opened");
  property p_narrow_zero;
    @(posedge bit_clk) disable iff (!rst_n)
      $changed(rx_tgl_q) && !$past(wide) |-> rx_word_q[15:8] == 8'h00;
  endproperty
  a_narrow_zero: assert property (p_narrow_zero) else $error("narrow word high byte set");
endmodule

//--- hdl/pcmfs_pkg.sv
// Purpose: shared constants for the PCM port front end (register map, fields, companding, gain)
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: gain table is Q8 (256 = 0 dB), one entry per 3 dB step from -24 dB
package pcmfs_pkg;
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_LINE_RX = 8'h08;
  localparam logic [7:0] OFF_MIC_RX = 8'h0c;
  localparam logic [7:0] OFF_SEND_OUT = 8'h10;
  localparam logic [7:0] OFF_RCV_OUT = 8'h14;
  // Control word: [1:0] pair wide (linear) select, [2] active-high frame pulse, [7:4] gain code
  localparam int unsigned CTRL_WIDE_LSB = 0;
  localparam int unsigned CTRL_GCI = 2;
  localparam int unsigned CTRL_GAIN_LSB = 4;
  localparam logic [1:0] WIDE_RESET = 2'h0;
  localparam logic GCI_RESET = 1'b0;
  localparam logic [3:0] GAIN_UNITY = 4'h8;
  // Status word: [0] SSI, [1] law pin, [2] format pin, [4:3] new sample, [6:5] width error,
  // [7] mode pins high while in SSI
  localparam int unsigned ST_NEW_LSB = 3;
  localparam int unsigned ST_ERR_LSB = 5;
  localparam logic [7:0] MASK_MU = 8'hff;
  localparam logic [7:0] MASK_A = 8'hd5;
  localparam logic [4:0] W_NARROW = 5'h08;
  localparam logic [4:0] W_WIDE = 5'h10;
  localparam logic [9:0] SSI_IDLE_CNT = 10'h3ff;
  localparam logic [15:0] MU_CLIP = 16'h1fde;
  localparam logic [15:0] MU_BIAS = 16'h0021;
  localparam logic [15:0] A_CLIP = 16'h0fff;
  localparam logic [11:0] GAIN_Q8 [16] = '{12'h010, 12'h017, 12'h020, 12'h02d,
                                           12'h040, 12'h05b, 12'h080, 12'h0b5,
                                           12'h100, 12'h16a, 12'h1ff, 12'h2d2,
                                           12'h400, 12'h5a4, 12'h7f5, 12'hb3b};
endpackage

//--- hdl/pcmfs_top.sv
// Purpose: PCM port front end: two serial port pairs, companding, speaker gain, APB registers
// Assumes: pclk is the 20 MHz master clock, bit_clock_in is the PCM bit clock, unrelated
// Notes: samples cross between domains by toggle handshakes with held data
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module pcmfs_top
  import pcmfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_clock_in,
  input wire logic frame_pulse_in,
  input wire logic pair_a_strobe,
  input wire logic pair_b_strobe,
  input wire logic pair_a_mode_bit,
  input wire logic pair_b_mode_bit,
  input wire logic line_rx_in,
  input wire logic mic_rx_in,
  input wire logic law_sel_in,
  input wire logic format_sel_in,
  output logic send_out,
  output logic send_out_oe_n,
  output logic rcv_out,
  output logic rcv_out_oe_n
);
  logic [1:0] lrst_q;
  logic lrst_n, fp_q, ssi_q, mode_err_l_q, frame_act;
  logic [9:0] idle_q;
  logic [8:0] pos_q;
  logic [1:0] mb_meta_q, mb_q, strobe_pins, din_pins, rx_bad, rx_tgl;
  logic [2:0] cfg_meta_q, cfg_l_q;
  logic [1:0] treq_meta_q, treq_l_q, tack_l_q;
  logic [15:0] tx_word_l_q [2];
  logic [15:0] rx_word [2];
  logic [1:0] dout, dout_oe_n;
  logic [3:0] pin_meta_q, pin_q;
  logic [1:0] rt_prev_q, rx_edge, ack_meta_q, ack_q, treq_q, pend_q, launch;
  logic [1:0] rt_meta_q, rt_sync_q;
  logic [1:0] new_q, err_q, wide_q;
  logic gci_q;
  logic [3:0] gain_q;
  logic [15:0] rx_lin_q [2];
  logic [15:0] stg_q [2];
  logic [15:0] tx_hold_q [2];
  logic [15:0] spk_sample;
  logic [31:0] prdata_q, rd_d;
  logic pready_q, pslverr_q, hit, commit;

  function automatic logic [15:0] pcmfs_expand(input logic [7:0] code, input logic alaw,
                                               input logic g711);
    logic [7:0] c;
    logic [15:0] m;
    c = g711 ? code ^ (alaw ? MASK_A : MASK_MU) : code;
    m = {11'h000, c[3:0], 1'b1};
    if (alaw)
      m = (c[6:4] == 3'h0) ? m << 3 : (m + 16'h0020) << ({1'b0, c[6:4]} + 4'h2);
    else
      m = (((m + 16'h0020) << c[6:4]) - MU_BIAS) << 2;
    return c[7] ? ~m + 16'h0001 : m;
  endfunction

  function automatic logic [7:0] pcmfs_compress(input logic [15:0] s, input logic alaw,
                                                input logic g711);
    logic [15:0] mag;
    logic [2:0] e;
    logic [3:0] mt;
    logic [7:0] c;
    mag = s[15] ? ~s + 16'h0001 : s;
    e = 3'h0;
    if (alaw)
    begin
      mag = mag >> 3;
      if (mag > A_CLIP)
        mag = A_CLIP;
      for (int i = 1; i < 8; i++)
        if (mag[i + 4])
          e = 3'(i);
      mt = (e == 3'h0) ? mag[4:1] : 4'(mag >> e);
    end
    else
    begin
      mag = mag >> 2;
      if (mag > MU_CLIP)
        mag = MU_CLIP;
      mag = mag + MU_BIAS;
      for (int i = 1; i < 8; i++)
        if (mag[i + 5])
          e = 3'(i);
      mt = 4'(mag >> ({1'b0, e} + 4'h1));
    end
    c = {s[15], e, mt};
    return g711 ? c ^ (alaw ? MASK_A : MASK_MU) : c;
  endfunction

  function automatic logic [15:0] pcmfs_gain(input logic [15:0] s, input logic [3:0] g);
    logic signed [28:0] p;
    logic [15:0] r;
    p = $signed(s) * $signed({1'b0, GAIN_Q8[g]});
    p = p >>> 8;
    if (p > 29'sd32767)
      r = 16'h7fff;
    else if (p < -29'sd32768)
      r = 16'h8000;
    else
      r = p[15:0];
    return r;
  endfunction

  // Link-domain reset: asserts at once, releases on the bit clock
  always_ff @(posedge bit_clock_in or negedge presetn)
  begin
    if (!presetn)
      lrst_q <= 2'h0;
    else
      lrst_q <= {lrst_q[0], 1'b1};
  end
  assign lrst_n = lrst_q[1];

  // A frame pin that never goes high for SSI_IDLE_CNT bit clocks is read as tied low
  always_ff @(posedge bit_clock_in or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      fp_q <= 1'b0;
      idle_q <= SSI_IDLE_CNT;
      ssi_q <= 1'b1;
    end
    else
    begin
      fp_q <= frame_pulse_in;
      if (fp_q)
        idle_q <= 10'h000;
      else if (idle_q != SSI_IDLE_CNT)
        idle_q <= idle_q + 10'h001;
      ssi_q <= !fp_q && idle_q == SSI_IDLE_CNT;
    end
  end

  assign frame_act = cfg_l_q[CTRL_GCI] ? fp_q : !fp_q;

  always_ff @(posedge bit_clock_in or negedge lrst_n)
  begin
    if (!lrst_n)
      pos_q <= 9'h000;
    else if (frame_act)
      pos_q <= 9'h000;
    else
      pos_q <= pos_q + 9'h001;
  end

  // Static levels entering the link domain
  always_ff @(posedge bit_clock_in or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      mb_meta_q <= 2'h0;
      mb_q <= 2'h0;
      cfg_meta_q <= 3'h0;
      cfg_l_q <= 3'h0;
      mode_err_l_q <= 1'b0;
    end
    else
    begin
      mb_meta_q <= {pair_b_mode_bit, pair_a_mode_bit};
      mb_q <= mb_meta_q;
      cfg_meta_q <= {gci_q, wide_q};
      cfg_l_q <= cfg_meta_q;
      mode_err_l_q <= ssi_q && (mb_q != 2'h0);
    end
  end

  // Transmit words taken from the master domain on a request toggle
  always_ff @(posedge bit_clock_in or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      treq_meta_q <= 2'h0;
      treq_l_q <= 2'h0;
      tack_l_q <= 2'h0;
      tx_word_l_q <= '{16'h0000, 16'h0000};
    end
    else
    begin
      treq_meta_q <= treq_q;
      treq_l_q <= treq_meta_q;
      for (int p = 0; p < 2; p++)
        if (treq_l_q[p] != tack_l_q[p])
        begin
          tx_word_l_q[p] <= tx_hold_q[p];
          tack_l_q[p] <= treq_l_q[p];
        end
    end
  end

  // Pair A: line receive in, send out; pair B: microphone in, speaker out
  assign strobe_pins = {pair_b_strobe, pair_a_strobe};
  assign din_pins = {mic_rx_in, line_rx_in};

  for (genvar p = 0; p < 2; p++)
  begin : g_pair
    pcmfs_pair u_pair (
      .bit_clk(bit_clock_in),
      .rst_n(lrst_n),
      .ssi(ssi_q),
      .pos(pos_q),
      .strobe_in(strobe_pins[p]),
      .mode_bit(mb_q[p]),
      .wide(cfg_l_q[CTRL_WIDE_LSB + p]),
      .din(din_pins[p]),
      .tx_word(tx_word_l_q[p]),
      .dout_q(dout[p]),
      .dout_oe_n_q(dout_oe_n[p]),
      .rx_word_q(rx_word[p]),
      .rx_bad_q(rx_bad[p]),
      .rx_tgl_q(rx_tgl[p])
    );
  end

  assign send_out = dout[0];
  assign send_out_oe_n = dout_oe_n[0];
  assign rcv_out = dout[1];
  assign rcv_out_oe_n = dout_oe_n[1];

  // Master-domain synchronisers: {format pin, law pin, mode error, SSI} and link acks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_q <= 4'h0;
      pin_q <= 4'h0;
      ack_meta_q <= 2'h0;
      ack_q <= 2'h0;
      rt_prev_q <= 2'h0;
    end
    else
    begin
      pin_meta_q <= {format_sel_in, law_sel_in, mode_err_l_q, ssi_q};
      pin_q <= pin_meta_q;
      ack_meta_q <= tack_l_q;
      ack_q <= ack_meta_q;
      rt_prev_q <= rt_sync_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rt_meta_q <= 2'h0;
      rt_sync_q <= 2'h0;
    end
    else
    begin
      rt_meta_q <= rx_tgl;
      rt_sync_q <= rt_meta_q;
    end
  end
  assign rx_edge = rt_sync_q ^ rt_prev_q;

  // Received words are held in the link domain until the next toggle, so they are stable here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_lin_q <= '{16'h0000, 16'h0000};
    else
      for (int p = 0; p < 2; p++)
        if (rx_edge[p])
          rx_lin_q[p] <= wide_q[p] ? rx_word[p] :
                         pcmfs_expand(rx_word[p][7:0], pin_q[2], pin_q[3]);
  end

  assign spk_sample = pcmfs_gain(stg_q[1], gain_q);
  assign launch = pend_q & ~(treq_q ^ ack_q);
  assign commit = psel && penable && pready_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_hold_q <= '{16'h0000, 16'h0000};
      treq_q <= 2'h0;
    end
    else
      for (int p = 0; p < 2; p++)
        if (launch[p])
        begin
          tx_hold_q[p] <= wide_q[p] ? (p == 1 ? spk_sample : stg_q[p]) :
                          {8'h00, pcmfs_compress(p == 1 ? spk_sample : stg_q[p],
                                                 pin_q[2], pin_q[3])};
          treq_q[p] <= !treq_q[p];
        end
  end

  // Register writes take effect at the edge that completes the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wide_q <= WIDE_RESET;
      gci_q <= GCI_RESET;
      gain_q <= GAIN_UNITY;
      stg_q <= '{16'h0000, 16'h0000};
      pend_q <= 2'h0;
      new_q <= 2'h0;
      err_q <= 2'h0;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        // A new event beats a clear in the same cycle
        if (rx_edge[p])
        begin
          new_q[p] <= 1'b1;
          err_q[p] <= err_q[p] | rx_bad[p];
        end
        else if (commit && pwrite && paddr == OFF_STATUS)
        begin
          new_q[p] <= new_q[p] & ~pwdata[ST_NEW_LSB + p];
          err_q[p] <= err_q[p] & ~pwdata[ST_ERR_LSB + p];
        end
        if (commit && pwrite && paddr == (p == 0 ? OFF_SEND_OUT : OFF_RCV_OUT))
        begin
          stg_q[p] <= pwdata[15:0];
          pend_q[p] <= 1'b1;
        end
        else if (launch[p])
          pend_q[p] <= 1'b0;
      end
      if (commit && pwrite && paddr == OFF_CTRL)
      begin
        wide_q <= pwdata[CTRL_WIDE_LSB +: 2];
        gci_q <= pwdata[CTRL_GCI];
        gain_q <= pwdata[CTRL_GAIN_LSB +: 4];
      end
    end
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      OFF_CTRL: rd_d = {24'h000000, gain_q, 1'b0, gci_q, wide_q};
      OFF_STATUS: rd_d = {24'h000000, pin_q[1], err_q, new_q, pin_q[3], pin_q[2], pin_q[0]};
      OFF_LINE_RX: rd_d = {16'h0000, rx_lin_q[0]};
      OFF_MIC_RX: rd_d = {16'h0000, rx_lin_q[1]};
      OFF_SEND_OUT: rd_d = {16'h0000, stg_q[0]};
      OFF_RCV_OUT: rd_d = {16'h0000, stg_q[1]};
      default: hit = 1'b0;
    endcase
  end

  // One wait state: the answer is registered so every bus output comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit;
      prdata_q <= (psel && penable && !pready_q && !pwrite) ? rd_d : 32'h0000_0000;
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  property p_unity_gain;
    @(posedge pclk) disable iff (!presetn)
      launch[1] && wide_q[1] && gain_q == GAIN_UNITY |=> tx_hold_q[1] == $past(stg_q[1]);
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("0 dB gain altered sample");
  property p_gain_top;
    @(posedge pclk) disable iff (!presetn)
      launch[1] && wide_q[1] && gain_q == 4'hf && stg_q[1] == 16'h0100
      |=> tx_hold_q[1] == 16'h0b3b;
  endproperty
  a_gain_top: assert property (p_gain_top) else $error("+21 dB gain wrong");
  property p_g711_mu;
    @(posedge pclk) disable iff (!presetn)
      launch[0] && !wide_q[0] && stg_q[0] == 16'h0000 && !pin_q[2] && pin_q[3]
      |=> tx_hold_q[0] == 16'h00ff;
  endproperty
  a_g711_mu: assert property (p_g711_mu) else $error("G.711 mu-law zero code wrong");
  property p_g711_a;
    @(posedge pclk) disable iff (!presetn)
      launch[0] && !wide_q[0] && stg_q[0] == 16'h0000 && pin_q[2] && pin_q[3]
      |=> tx_hold_q[0] == 16'h00d5;
  endproperty
  a_g711_a: assert property (p_g711_a) else $error("A-law zero code wrong");
  property p_line_route;
    @(posedge pclk) disable iff (!presetn) $changed(rx_lin_q[0]) |-> $past(rx_edge[0]);
  endproperty
  a_line_route: assert property (p_line_route) else $error("line sample from wrong pair");
  property p_rx_new;
    @(posedge pclk) disable iff (!presetn) rx_edge[1] |=> new_q[1];
  endproperty
  a_rx_new: assert property (p_rx_new) else $error("crossed sample not flagged");
  property p_frame_seen;
    @(posedge bit_clock_in) disable iff (!lrst_n) fp_q |=> !ssi_q;
  endproperty
  a_frame_seen: assert property (p_frame_seen) else $error("SSI kept with frame pulse");
  property p_ssi_enter;
    @(posedge bit_clock_in) disable iff (!lrst_n)
      !fp_q && idle_q == SSI_IDLE_CNT |=> ssi_q;
  endproperty
  a_ssi_enter: assert property (p_ssi_enter) else $error("SSI not entered");
endmodule

//--- testbench/pcm_port_format_select_test.sv
// Purpose: self-checking bench of the PCM port front end
// Assumes: SSI operation, frame pin held low until the closing framed-mode check
// Notes: expected samples are built in the bench, never read back from the design
`timescale 1ns/10ps
module pcm_port_format_select_test;
  import pcmfs_pkg::*;
  logic pclk = 1'b0;
  logic bclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sa, sb, la, lb, so, so_oe_n, ro, ro_oe_n;
  logic md_a = 1'b0;
  logic law = 1'b0;
  logic fmt = 1'b0;
  logic fp = 1'b0;
  logic [15:0] exp_q [$];
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rnd = 32'h7d3e;

  always #25 pclk = ~pclk;
  always #32 bclk = ~bclk;

  // Frame pin held low selects SSI; pair B mode pin low as SSI asks
  pcmfs_top i_pcmfs_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_clock_in(bclk), .frame_pulse_in(fp), .pair_a_strobe(sa),
    .pair_b_strobe(sb), .pair_a_mode_bit(md_a), .pair_b_mode_bit(1'b0), .line_rx_in(la),
    .mic_rx_in(lb), .law_sel_in(law), .format_sel_in(fmt), .send_out(so),
    .send_out_oe_n(so_oe_n), .rcv_out(ro), .rcv_out_oe_n(ro_oe_n));
  pcmfs_codec i_pcmfs_codec_a (.bit_clk(bclk), .strobe(sa), .din(la), .dout(so),
    .oe_n(so_oe_n));
  pcmfs_codec i_pcmfs_codec_b (.bit_clk(bclk), .strobe(sb), .din(lb), .dout(ro),
    .oe_n(ro_oe_n));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    if (k >= 20)
    begin
      n_fail++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(nm, rd & m, exp);
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      stop_test();
    end
  end

  initial
  begin
    logic [31:0] d;
    logic e, oa, ob;
    logic [15:0] s, wa, ga, gb;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", OFF_CTRL, 32'hff, 32'h80);
    rchk("status", OFF_STATUS, 32'hff, 32'h01);
    apb(1'b0, 8'h18, 32'h0, d, e);
    chk("bad_err", {31'h0, e}, 32'h1);
    chk("bad_data", d, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      law <= m[0];
      fmt <= m[1];
      repeat (8) @(posedge pclk);
      rchk("pins", OFF_STATUS, 32'h6, {29'h0, m[1], m[0], 1'b0});
    end
    md_a <= 1'b1;
    repeat (8) @(posedge pclk);
    rchk("mode_in_ssi", OFF_STATUS, 32'h80, 32'h80);
    md_a <= 1'b0;
    rnd = lfsr(rnd);
    // Pair A wide and linear, pair B narrow and companded
    wr(OFF_CTRL, {24'h0, rnd[3:0], 4'h1});
    rchk("ctrl_rb", OFF_CTRL, 32'hf3, {24'h0, rnd[3:0], 4'h1});
    for (int f = 0; f < 4; f++)
    begin
      rnd = lfsr(rnd);
      s = rnd[15:0];
      rnd = lfsr(rnd);
      wa = rnd[15:0];
      law <= 1'b0;
      fmt <= f[0];
      wr(OFF_SEND_OUT, {16'h0, s});
      exp_q.push_back(s);
      // Rewritten each pass so the companded word follows the new format pin
      wr(OFF_RCV_OUT, 32'h0);
      rchk("send_rb", OFF_SEND_OUT, 32'hffff, {16'h0, s});
      fork
        i_pcmfs_codec_a.xfer(16, wa, ga, oa);
        i_pcmfs_codec_b.xfer(8, f[0] ? 16'hff : 16'h00, gb, ob);
      join
      rchk("line", OFF_LINE_RX, 32'hffff, {16'h0, wa});
      rchk("mic", OFF_MIC_RX, 32'hffff, 32'h0);
      chk("sout", {16'h0, ga}, {16'h0, exp_q.pop_front()});
      chk("rout", {24'h0, gb[7:0]}, f[0] ? 32'hff : 32'h0);
      chk("oe", {30'h0, oa, ob}, 32'h3);
      rchk("new", OFF_STATUS, 32'h78, 32'h18);
      wr(OFF_STATUS, 32'h18);
      rchk("new_clr", OFF_STATUS, 32'h18, 32'h0);
    end
    i_pcmfs_codec_a.xfer(12, wa, ga, oa);
    rchk("width_err", OFF_STATUS, 32'h60, 32'h20);
    wr(OFF_STATUS, 32'h78);
    rchk("err_clr", OFF_STATUS, 32'h78, 32'h0);
    // Pair A narrow with A-law G.711, pair B wide at the top gain step
    law <= 1'b1;
    wr(OFF_CTRL, 32'hf2);
    wr(OFF_SEND_OUT, 32'h0);
    wr(OFF_RCV_OUT, 32'h100);
    fork
      i_pcmfs_codec_a.xfer(8, 16'h00d5, ga, oa);
      i_pcmfs_codec_b.xfer(16, wa, gb, ob);
    join
    chk("a_zero", {24'h0, ga[7:0]}, {24'h0, MASK_A});
    chk("gain_top", {16'h0, gb}, {20'h0, GAIN_Q8[15]});
    rchk("mic_wide", OFF_MIC_RX, 32'hffff, {16'h0, wa});
    // A frame pulse seen high leaves SSI
    fp <= 1'b1;
    repeat (8) @(posedge pclk);
    rchk("framed", OFF_STATUS, 32'h1, 32'h0);
    stop_test();
  end
endmodule

//--- testbench/pcmfs_codec.sv
// Purpose: codec model standing on one PCM port pair
// Assumes: bit clock runs free; strobe active high, synchronous to the bit clock
// Notes: data line shows the inverse of its last bit outside the window
`timescale 1ns/10ps
module pcmfs_codec (
  input wire logic bit_clk,
  output logic strobe,
  output logic din,
  input wire logic dout,
  input wire logic oe_n
);
  initial
  begin
    strobe = 1'b0;
    din = 1'b0;
  end
  // One 125 us frame of 1953 bit clocks; output bit k is looked at three edges after window bit k
  task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] got,
                      output logic oe_ok);
    got = 16'h0;
    oe_ok = 1'b1;
    for (int i = 0; i < 1953; i++)
    begin
      @(posedge bit_clk);
      if (i >= 11 && i < n + 11)
      begin
        got = {got[14:0], dout};
        oe_ok &= (oe_n === 1'b0);
      end
      strobe <= (i >= 8 && i < n + 8);
      din <= (i >= 8 && i < n + 8) ? w[n + 7 - i] : ~din;
    end
  endtask
endmodule
